// *** adc_cfg_pkg.sv ***
// constants shared by the converter configuration and serial readout block
package adc_cfg_pkg;
  // register port addresses
  localparam logic [3:0] CFG_ADDR = 4'h0;
  localparam logic [3:0] STAT_ADDR = 4'h4;
  // configuration word reset value and never-stored bits
  localparam logic [31:0] CFG_DEFAULT = 32'h000003ff;
  localparam logic [31:0] CFG_UNUSED_MASK = 32'h00031c00;
  // configuration field positions
  localparam int WEN_BIT = 31;
  localparam int CONVERSION_CLOCK_SOURCE_SELECT_BIT = 29;
  localparam int INT_MODE_BIT = 27;
  localparam int POL_BIT = 26;
  localparam int RANGE_A_BIT = 24;
  localparam int RANGE_B_BIT = 23;
  localparam int PD_B_BIT = 22;
  localparam int RANGE_C_BIT = 21;
  localparam int PD_C_BIT = 20;
  localparam int RANGE_D_BIT = 19;
  localparam int PD_D_BIT = 18;
  localparam int REF_EN_BIT = 15;
  localparam int REF_BUF_BIT = 14;
  localparam int VREF_BIT = 13;
  localparam int DAC_MSB = 9;
  // serial word sizes
  localparam int WORD_BITS = 16;
  localparam logic [4:0] CFG_LAST_BIT = 5'h1f;
  // synchronised pin vector layout and idle levels
  localparam int PIN_IFS = 0;
  localparam int PIN_HW = 1;
  localparam int PIN_FS = 2;
  localparam int PIN_SCLK = 3;
  localparam int PIN_SDI = 4;
  localparam int PIN_SELB = 5;
  localparam int PIN_SELCD = 6;
  localparam int PIN_HWRANGE = 7;
  localparam int PIN_HWREF = 8;
  localparam int PIN_COUNT = 9;
  localparam logic [8:0] PIN_RESET = 9'h004;
  // status register fields
  localparam int ST_FRAME = 0;
  localparam int ST_INT = 1;
  localparam int ST_SERIAL = 2;
  localparam int ST_HW = 3;
  localparam int ST_BUSY = 4;
endpackage

// *** adc_config_and_serial_readout.sv ***
// configuration word, status pin and serial readout of an 8-channel converter
`timescale 1ns/1ps
`default_nettype none
module adc_config_and_serial_readout
  import adc_cfg_pkg::*;
#(
  parameter int RESOLUTION = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // device pins, asynchronous to clk
  input wire logic interfaceTypeSelect,
  input wire logic hardwareModeSelect,
  input wire logic frameSyncInput,
  input wire logic sclk,
  input wire logic serialConfigInput,
  input wire logic outBSelect,
  input wire logic thirdFourthOutputSelect,
  input wire logic hwRangeSelect,
  input wire logic hwReferenceEnable,
  // conversion core, same clock
  input wire logic convBusy,
  input wire logic convDone,
  input wire logic [RESOLUTION-1:0] chA0,
  input wire logic [RESOLUTION-1:0] chA1,
  input wire logic [RESOLUTION-1:0] chB0,
  input wire logic [RESOLUTION-1:0] chB1,
  input wire logic [RESOLUTION-1:0] chC0,
  input wire logic [RESOLUTION-1:0] chC1,
  input wire logic [RESOLUTION-1:0] chD0,
  input wire logic [RESOLUTION-1:0] chD1,
  // serial data outputs
  output logic serialOutA,
  output logic serialOutB,
  output logic serialOutC,
  output logic serialOutD,
  // status pin and effective analog controls
  output logic statusOut,
  output logic conversionClockSourceSelect,
  output logic [3:0] rangeTwiceRef,
  output logic [2:0] pairPowerDown,
  output logic referenceEnable,
  output logic referenceBufferDisable,
  output logic referenceVoltage3v,
  output logic [9:0] referenceDacCode
);

  function automatic logic [WORD_BITS-1:0] sx(
    input logic [RESOLUTION-1:0] v
  );
    sx = WORD_BITS'($signed(v));
  endfunction

  // pin synchroniser: three stages, a change counts once stages 2 and 3 agree
  logic [PIN_COUNT-1:0] pinIn, s1, s2, s3, filt, next_filt;
  assign pinIn = {hwReferenceEnable, hwRangeSelect, thirdFourthOutputSelect,
                  outBSelect, serialConfigInput, sclk, frameSyncInput,
                  hardwareModeSelect, interfaceTypeSelect};

  always_comb begin
    next_filt = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & filt);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= PIN_RESET;
      s2 <= PIN_RESET;
      s3 <= PIN_RESET;
      filt <= PIN_RESET;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end

  // edge detection on the filtered levels
  logic fsPrev, sclkPrev;
  logic fsFall, fsRise, sclkFall, serialMode, hwMode, sdiBit;
  assign fsFall = fsPrev & ~filt[PIN_FS];
  assign fsRise = ~fsPrev & filt[PIN_FS];
  assign sclkFall = sclkPrev & ~filt[PIN_SCLK];
  assign serialMode = filt[PIN_IFS];
  assign hwMode = filt[PIN_HW];
  assign sdiBit = filt[PIN_SDI];

  // core state
  logic [31:0] cfgWord, next_cfgWord;
  logic frameActive, next_frameActive;
  logic intFlag, next_intFlag;
  logic [127:0] shA, next_shA;
  logic [63:0] shB, next_shB;
  logic [31:0] shC, next_shC;
  logic [31:0] shD, next_shD;
  logic [31:0] sdiShift, next_sdiShift;
  logic [4:0] sdiCount, next_sdiCount;
  logic [31:0] next_regRdata;
  logic next_serialOutA, next_serialOutB, next_serialOutC, next_serialOutD;
  logic next_statusOut, next_conversion_clock_source_select, next_refEn, next_refBufDis;
  logic [3:0] next_range;
  logic [31:0] sdiWord;
  logic frameStart;

  assign frameStart = fsFall & serialMode;
  assign sdiWord = {sdiShift[30:0], sdiBit};

  always_comb begin
    next_cfgWord = cfgWord;
    next_frameActive = frameActive;
    next_intFlag = intFlag;
    next_shA = shA;
    next_shB = shB;
    next_shC = shC;
    next_shD = shD;
    next_sdiShift = sdiShift;
    next_sdiCount = sdiCount;
    next_regRdata = 32'h00000000;
    // frame framing and shifting
    if (frameStart) begin
      next_frameActive = 1'b1;
      next_sdiCount = 5'h00;
      next_sdiShift = 32'h00000000;
      if (filt[PIN_SELCD]) begin
        next_shA = {sx(chA0), sx(chA1), 96'h0};
        next_shB = {sx(chB0), sx(chB1), 32'h0};
        next_shC = {sx(chC0), sx(chC1)};
        next_shD = {sx(chD0), sx(chD1)};
      end else if (filt[PIN_SELB]) begin
        next_shA = {sx(chA0), sx(chA1), sx(chC0), sx(chC1), 64'h0};
        next_shB = {sx(chB0), sx(chB1), sx(chD0), sx(chD1)};
        next_shC = 32'h00000000;
        next_shD = 32'h00000000;
      end else begin
        next_shA = {sx(chA0), sx(chA1), sx(chB0), sx(chB1),
                    sx(chC0), sx(chC1), sx(chD0), sx(chD1)};
        next_shB = 64'h0;
        next_shC = 32'h00000000;
        next_shD = 32'h00000000;
      end
    end else if (fsRise) begin
      next_frameActive = 1'b0;
    end else if (frameActive && sclkFall) begin
      next_shA = {shA[126:0], 1'b0};
      next_shB = {shB[62:0], 1'b0};
      next_shC = {shC[30:0], 1'b0};
      next_shD = {shD[30:0], 1'b0};
      next_sdiShift = sdiWord;
      next_sdiCount = sdiCount + 5'h01;
      // a 32-bit word with its write-enable bit set replaces the config
      if (sdiCount == CFG_LAST_BIT && sdiWord[WEN_BIT]) begin
        next_cfgWord = sdiWord & ~CFG_UNUSED_MASK;
      end
    end
    // the bus write wins over a serial write landing in the same cycle
    if (regWrite && regAddr == CFG_ADDR) begin
      next_cfgWord = regWdata & ~CFG_UNUSED_MASK;
    end
    if (regRead) begin
      if (regAddr == CFG_ADDR) begin
        next_regRdata = cfgWord;
      end else if (regAddr == STAT_ADDR) begin
        next_regRdata[ST_FRAME] = frameActive;
        next_regRdata[ST_INT] = intFlag;
        next_regRdata[ST_SERIAL] = serialMode;
        next_regRdata[ST_HW] = hwMode;
        next_regRdata[ST_BUSY] = convBusy;
      end
    end
    // interrupt: end of conversion sets, next frame sync fall clears in either interface mode, set wins
    if (convDone) begin
      next_intFlag = 1'b1;
    end else if (fsFall) begin
      next_intFlag = 1'b0;
    end
    // outputs stay low outside a frame and when their port is off
    next_serialOutA = next_frameActive & next_shA[127];
    next_serialOutB = next_frameActive & filt[PIN_SELB] & next_shB[63];
    next_serialOutC = next_frameActive & filt[PIN_SELCD] & next_shC[31];
    next_serialOutD = next_frameActive & filt[PIN_SELCD] & next_shD[31];
    // status pin keeps its mode and polarity in hardware mode too
    next_statusOut = (cfgWord[INT_MODE_BIT] ? intFlag : convBusy)
                     ^ cfgWord[POL_BIT];
    next_conversion_clock_source_select = ~hwMode & cfgWord[CONVERSION_CLOCK_SOURCE_SELECT_BIT];
    if (hwMode) begin
      next_range = {4{filt[PIN_HWRANGE]}};
      next_refEn = filt[PIN_HWREF];
      next_refBufDis = ~serialMode & cfgWord[REF_BUF_BIT];
    end else begin
      next_range = {cfgWord[RANGE_A_BIT], cfgWord[RANGE_B_BIT],
                    cfgWord[RANGE_C_BIT], cfgWord[RANGE_D_BIT]};
      next_refEn = cfgWord[REF_EN_BIT];
      next_refBufDis = cfgWord[REF_BUF_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fsPrev <= 1'b1;
      sclkPrev <= 1'b0;
      cfgWord <= CFG_DEFAULT;
      frameActive <= 1'b0;
      intFlag <= 1'b0;
      shA <= 128'h0;
      shB <= 64'h0;
      shC <= 32'h00000000;
      shD <= 32'h00000000;
      sdiShift <= 32'h00000000;
      sdiCount <= 5'h00;
      regRdata <= 32'h00000000;
      serialOutA <= 1'b0;
      serialOutB <= 1'b0;
      serialOutC <= 1'b0;
      serialOutD <= 1'b0;
      statusOut <= 1'b0;
      conversionClockSourceSelect <= 1'b0;
      rangeTwiceRef <= 4'h0;
      pairPowerDown <= 3'h0;
      referenceEnable <= 1'b0;
      referenceBufferDisable <= 1'b0;
      referenceVoltage3v <= 1'b0;
      referenceDacCode <= CFG_DEFAULT[DAC_MSB:0];
    end else begin
      fsPrev <= filt[PIN_FS];
      sclkPrev <= filt[PIN_SCLK];
      cfgWord <= next_cfgWord;
      frameActive <= next_frameActive;
      intFlag <= next_intFlag;
      shA <= next_shA;
      shB <= next_shB;
      shC <= next_shC;
      shD <= next_shD;
      sdiShift <= next_sdiShift;
      sdiCount <= next_sdiCount;
      regRdata <= next_regRdata;
      serialOutA <= next_serialOutA;
      serialOutB <= next_serialOutB;
      serialOutC <= next_serialOutC;
      serialOutD <= next_serialOutD;
      statusOut <= next_statusOut;
      conversionClockSourceSelect <= next_conversion_clock_source_select;
      rangeTwiceRef <= next_range;
      pairPowerDown <= {cfgWord[PD_B_BIT], cfgWord[PD_C_BIT],
                        cfgWord[PD_D_BIT]};
      referenceEnable <= next_refEn;
      referenceBufferDisable <= next_refBufDis;
      referenceVoltage3v <= cfgWord[VREF_BIT];
      referenceDacCode <= cfgWord[DAC_MSB:0];
    end
  end

  // checks
  property p_cfgReset;
    @(posedge clk) !resetn |-> cfgWord == CFG_DEFAULT;
  endproperty
  a_cfgReset: assert property (p_cfgReset)
    else $error("config not at default under reset");

  property p_unused;
    @(posedge clk) disable iff (!resetn)
      (cfgWord & CFG_UNUSED_MASK) == 32'h00000000;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused config bits not zero");

  property p_conversion_clock_source_select;
    @(posedge clk) disable iff (!resetn)
      hwMode |=> !conversionClockSourceSelect;
  endproperty
  a_conversion_clock_source_select: assert property (p_conversion_clock_source_select)
    else $error("external clock selected in hardware mode");

  property p_status;
    @(posedge clk) disable iff (!resetn)
      !cfgWord[INT_MODE_BIT] && cfgWord[POL_BIT] && convBusy |=> !statusOut;
  endproperty
  a_status: assert property (p_status)
    else $error("low-active busy not driven low");

  property p_hwRange;
    @(posedge clk) disable iff (!resetn)
      hwMode |=> rangeTwiceRef == {4{$past(filt[PIN_HWRANGE])}};
  endproperty
  a_hwRange: assert property (p_hwRange)
    else $error("range not pin-selected in hardware mode");

  property p_bufSerialHw;
    @(posedge clk) disable iff (!resetn)
      hwMode && serialMode |=> !referenceBufferDisable;
  endproperty
  a_bufSerialHw: assert property (p_bufSerialHw)
    else $error("buffer disable acted in hardware serial mode");

  property p_dac;
    @(posedge clk) disable iff (!resetn)
      1'b1 |=> referenceDacCode == $past(cfgWord[DAC_MSB:0]);
  endproperty
  a_dac: assert property (p_dac)
    else $error("dac code does not follow config");

  property p_frameStart;
    @(posedge clk) disable iff (!resetn)
      frameStart |=> frameActive && sdiCount == 5'h00;
  endproperty
  a_frameStart: assert property (p_frameStart)
    else $error("frame did not start on frame sync fall");

  property p_shift;
    @(posedge clk) disable iff (!resetn)
      frameActive && sclkFall && !frameStart && !fsRise
      |=> shA == {$past(shA[126:0]), 1'b0} && serialOutA == shA[127];
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial output not advanced on sclk fall");

  property p_oneOrder;
    @(posedge clk) disable iff (!resetn)
      frameStart && !filt[PIN_SELB] && !filt[PIN_SELCD]
      |=> shA[111:96] == $past(sx(chA1)) && shA[95:80] == $past(sx(chB0));
  endproperty
  a_oneOrder: assert property (p_oneOrder)
    else $error("single-output word order wrong");

  property p_twoOrder;
    @(posedge clk) disable iff (!resetn)
      frameStart && filt[PIN_SELB] && !filt[PIN_SELCD]
      |=> shA[95:80] == $past(sx(chC0)) && shB[31:16] == $past(sx(chD0));
  endproperty
  a_twoOrder: assert property (p_twoOrder)
    else $error("two-output word order wrong");

  property p_outB;
    @(posedge clk) disable iff (!resetn)
      !filt[PIN_SELB] |=> !serialOutB;
  endproperty
  a_outB: assert property (p_outB)
    else $error("output B active while deselected");

  property p_sdiWrite;
    @(posedge clk) disable iff (!resetn)
      frameActive && sclkFall && !frameStart && !fsRise && !regWrite
      && sdiCount == CFG_LAST_BIT && sdiShift[30]
      |=> cfgWord == ($past(sdiWord) & ~CFG_UNUSED_MASK);
  endproperty
  a_sdiWrite: assert property (p_sdiWrite)
    else $error("serial config word not taken");

endmodule
`default_nettype wire

// *** host_serial_model.sv ***
// host controller model that frames serial readouts and shifts config bits
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  // bench clock
  input wire logic clk,
  // serial pins
  output logic frameSync,
  output logic sclk,
  output logic serial_config_input,
  input wire logic [3:0] sdo
);
  initial begin
    frameSync = 1'b1;
    sclk = 1'b0;
    serial_config_input = 1'b0;
  end

  // sclk stands low between frames; bits are taken mid high phase, far
  // from the falling edge that moves them
  task automatic frame(input int n, input logic [31:0] w,
                       output logic [3:0][127:0] q);
    q = '0;
    @(posedge clk);
    frameSync <= 1'b0;
    repeat (16) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      serial_config_input <= w[31 - (i % 32)];
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
      for (int j = 0; j < 4; j++) q[j][127 - i] = sdo[j];
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
      repeat (16) @(posedge clk);
    end
    frameSync <= 1'b1;
    // released data line shows the inverse, not a held value
    serial_config_input <= ~serial_config_input;
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the converter configuration and serial readout
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adc_cfg_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdata;
  logic ifs = 1'b0, hw = 1'b0, selB = 1'b0, selCD = 1'b0;
  logic hwRange = 1'b0, hwRef = 1'b0, convBusy = 1'b0, convDone = 1'b0;
  logic [11:0] ch [8];
  logic frameSync, sclk, serial_config_input, statusOut;
  wire [3:0] sdo;
  wire [20:0] eff;
  integer seed = 32'hd6b409d6;
  int n_errors = 0;
  int check_count = 0;
  int o;
  logic [31:0] cfg, rdv;
  logic [3:0][127:0] got, expv;
  logic [15:0] q [4][$];

  always #2.5 clk = ~clk;

  adc_config_and_serial_readout #(.RESOLUTION(12)) dut (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .interfaceTypeSelect(ifs), .hardwareModeSelect(hw),
    .frameSyncInput(frameSync), .sclk(sclk), .serialConfigInput(serial_config_input),
    .outBSelect(selB), .thirdFourthOutputSelect(selCD),
    .hwRangeSelect(hwRange), .hwReferenceEnable(hwRef),
    .convBusy(convBusy), .convDone(convDone),
    .chA0(ch[0]), .chA1(ch[1]), .chB0(ch[2]), .chB1(ch[3]),
    .chC0(ch[4]), .chC1(ch[5]), .chD0(ch[6]), .chD1(ch[7]),
    .serialOutA(sdo[0]), .serialOutB(sdo[1]), .serialOutC(sdo[2]),
    .serialOutD(sdo[3]), .statusOut(statusOut),
    .conversionClockSourceSelect(eff[20]), .rangeTwiceRef(eff[19:16]),
    .pairPowerDown(eff[15:13]), .referenceEnable(eff[12]),
    .referenceBufferDisable(eff[11]), .referenceVoltage3v(eff[10]),
    .referenceDacCode(eff[9:0]));

  host_serial_model host (.clk(clk), .frameSync(frameSync), .sclk(sclk),
    .serial_config_input(serial_config_input), .sdo(sdo));

  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // effective analog controls as the pins and the word should set them
  function automatic logic [20:0] effExp(input logic [31:0] c);
    return {hw ? 1'b0 : c[29],
      hw ? {4{hwRange}} : {c[24], c[23], c[21], c[19]},
      c[22], c[20], c[18], hw ? hwRef : c[15],
      (hw && ifs) ? 1'b0 : c[14], c[13], c[9:0]};
  endfunction

  initial begin
    for (int i = 0; i < 8; i++) ch[i] = 12'h000;
    // a real falling edge, so the asynchronous reset acts before the clock
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(CFG_ADDR, rdv);
    chk(rdv, CFG_DEFAULT);
    chk(eff, effExp(CFG_DEFAULT));
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      {hw, ifs, hwRange, hwRef, convBusy} <= 5'($random(seed));
      rdv = (k == 0) ? 32'hffffffff : $random(seed);
      wr(CFG_ADDR, rdv);
      cfg = rdv & ~CFG_UNUSED_MASK;
      repeat (6) @(posedge clk);
      rd(CFG_ADDR, rdv);
      chk(rdv, cfg);
      chk(eff, effExp(cfg));
      chk(statusOut, (cfg[27] ? 1'b0 : convBusy) ^ cfg[26]);
      rd(STAT_ADDR, rdv);
      chk(rdv[4:2], {convBusy, hw, ifs});
    end
    // refused places leave the word alone
    wr(STAT_ADDR, 32'h0);
    wr(4'hc, 32'h0);
    rd(4'hc, rdv);
    chk(rdv, 32'h0);
    rd(CFG_ADDR, rdv);
    chk(rdv, cfg);
    // interrupt mode: set by conversion end, cleared by a frame start
    @(posedge clk);
    hw <= 1'b0;
    ifs <= 1'b1;
    convBusy <= 1'b0;
    cfg = 32'h080003ff;
    wr(CFG_ADDR, cfg);
    @(posedge clk);
    convDone <= 1'b1;
    @(posedge clk);
    convDone <= 1'b0;
    repeat (3) @(posedge clk);
    chk(statusOut, 1'b1);
    host.frame(2, 32'h0, got);
    repeat (4) @(posedge clk);
    chk(statusOut, 1'b0);
    // every output selection, then one frame in parallel mode
    for (int c = 0; c < 5; c++) begin
      @(posedge clk);
      for (int i = 0; i < 8; i++) ch[i] <= 12'($random(seed));
      {selCD, selB} <= c[1:0];
      ifs <= (c < 4);
      rdv = $random(seed) & ~32'h00540000;
      if (c == 4) rdv[31] = 1'b0;
      repeat (8) @(posedge clk);
      host.frame(128, rdv, got);
      for (int j = 0; j < 4; j++) q[j] = {};
      for (int i = 0; i < 8 && c < 4; i++) begin
        o = selCD ? i / 2 : (selB ? (i / 2) % 2 : 0);
        if (!(selCD && !selB && o == 1))
          q[o].push_back({{4{ch[i][11]}}, ch[i]});
      end
      expv = '0;
      for (int j = 0; j < 4; j++)
        for (int k = 0; k < q[j].size(); k++)
          expv[j][127 - 16 * k -: 16] = q[j][k];
      for (int j = 0; j < 4; j++)
        chk(got[j], expv[j]);
      if (rdv[31]) cfg = rdv & ~CFG_UNUSED_MASK;
      rd(CFG_ADDR, rdv);
      chk(rdv, cfg);
    end
    // reset again in mid-run
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(CFG_ADDR, rdv);
    chk(rdv, CFG_DEFAULT);
    final_report;
  end

  // the whole run needs about 21000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    final_report;
  end
endmodule
`default_nettype wire
